// file: inc/nv_store_regs.vh
// Register map, field positions, reset values and timing for the emulated NV word store
`ifndef NV_STORE_REGS_VH
`define NV_STORE_REGS_VH

// Byte offsets of the four registers on the AXI4-Lite bus
`define NV_OFF_WORD_ADDRESS 8'h00
`define NV_OFF_DATA_LOW 8'h04
`define NV_OFF_DATA_HIGH 8'h08
`define NV_OFF_CONTROL 8'h0C

// Store geometry
`define NV_WORDS 32
`define NV_WORD_W 14
`define NV_ADDR_W 5
`define NV_HIGH_W 6

// Control register field positions
`define NV_CTL_SEL_HI 7
`define NV_CTL_SEL_LO 6
`define NV_CTL_ERASE_EN 5
`define NV_CTL_ERASE_TRIG 4
`define NV_CTL_WRITE_EN 3
`define NV_CTL_WRITE_TRIG 2
`define NV_CTL_READ_EN 1
`define NV_CTL_READ_TRIG 0

// Reset values
`define NV_RST_WORD_ADDRESS 5'h00
`define NV_RST_DATA_LOW 8'h00
`define NV_RST_DATA_HIGH 6'h00
`define NV_RST_CONTROL 8'h00

// Timing: clock rate, shortest program time, read access time
`define NV_CLK_MHZ 200
`define NV_CLK_PERIOD_NS 5
`define NV_PROG_BASE_US 2000
`define NV_PROG_BASE_CYCLES (`NV_PROG_BASE_US * `NV_CLK_MHZ)
`define NV_READ_NS 10
`define NV_READ_CYCLES ((`NV_READ_NS + `NV_CLK_PERIOD_NS - 1) / `NV_CLK_PERIOD_NS)
`define NV_CNT_W 23

// AXI response codes
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// file: verilog/emulated_nv_word_store_ctrl.v
// Emulated non-volatile word store controller with AXI4-Lite register access
//
// Functional notes
// - Store holds 32 words of 14 bits; erase clears the page, write/read one word.
// - Address register: 5-bit word address, reset zero, bits 7..5 read zero.
// - Data low register: full 8-bit read/write, word bits 7..0, reset zero.
// - Data high register: word bits 13..8 in low six bits, top two read zero.
// - Duration select 00/01/10/11 gives 2, 4, 8, 16 ms erase/write time.
// - Erase enable must be set first; cleared at erase end; zero blocks erase.
// - Erase trigger starts erase only when enable already set; cleared at end.
// - Write enable must be set first; cleared at write end; zero blocks write.
// - Write trigger starts word write only when enable already set; cleared at end.
// - Read enable must be set first; zero blocks reads; never auto-cleared.
// - Read trigger with read enable set reads one word; trigger cleared at end.
// - Processor is stalled from a started operation until it completes.
// - After an erase every word of the page reads as zero.
`timescale 1ns/1ps
`include "nv_store_regs.vh"

module emulated_nv_word_store_ctrl #(
    parameter integer PROG_BASE_CYCLES = `NV_PROG_BASE_CYCLES
) (
    // Clock and reset
    input wire clock,
    input wire rst,
    // AXI4-Lite write address channel
    input wire [7:0] awaddr,
    input wire [2:0] awprot,
    input wire awvalid,
    output wire awready,
    // AXI4-Lite write data channel
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    // AXI4-Lite write response channel
    output wire [1:0] bresp,
    output wire bvalid,
    input wire bready,
    // AXI4-Lite read address channel
    input wire [7:0] araddr,
    input wire [2:0] arprot,
    input wire arvalid,
    output wire arready,
    // AXI4-Lite read data channel
    output wire [31:0] rdata,
    output wire [1:0] rresp,
    output wire rvalid,
    input wire rready,
    // Processor stall while an operation runs
    output wire cpuStall
);

    // Operation states
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_ERASE = 2'b01;
    localparam [1:0] ST_WRITE = 2'b10;
    localparam [1:0] ST_READ = 2'b11;

    // Counter load values at counter width
    localparam [`NV_CNT_W-1:0] BASE_CNT = PROG_BASE_CYCLES[`NV_CNT_W-1:0];
    localparam integer READ_CYCLES = `NV_READ_CYCLES;
    localparam [`NV_CNT_W-1:0] CNT_ONE = 23'h000001;

    // Register index codes returned by the decoder
    localparam [2:0] IDX_NONE = 3'h0;
    localparam [2:0] IDX_ADDR = 3'h4;
    localparam [2:0] IDX_LOW = 3'h5;
    localparam [2:0] IDX_HIGH = 3'h6;
    localparam [2:0] IDX_CTL = 3'h7;

    // Address decode shared by the read and write paths; unmapped gives IDX_NONE
    function [2:0] regIndex;
        input [7:0] addr;
        begin
            case (addr)
                `NV_OFF_WORD_ADDRESS: regIndex = IDX_ADDR;
                `NV_OFF_DATA_LOW: regIndex = IDX_LOW;
                `NV_OFF_DATA_HIGH: regIndex = IDX_HIGH;
                `NV_OFF_CONTROL: regIndex = IDX_CTL;
                default: regIndex = IDX_NONE;
            endcase
        end
    endfunction

    // Erase/write duration: shortest time doubled per select step
    function [`NV_CNT_W-1:0] progCycles;
        input [1:0] sel;
        begin
            progCycles = BASE_CNT << sel;
        end
    endfunction

    // Storage array; no reset because the contents are meant to persist
    reg [`NV_WORD_W-1:0] store [0:`NV_WORDS-1];

    // Software-visible registers
    reg [`NV_ADDR_W-1:0] wordAddr_ff;
    reg [7:0] dataLow_ff;
    reg [`NV_HIGH_W-1:0] dataHigh_ff;
    reg [7:0] control_ff;
    reg [`NV_ADDR_W-1:0] nxt_wordAddr;
    reg [7:0] nxt_dataLow;
    reg [`NV_HIGH_W-1:0] nxt_dataHigh;
    reg [7:0] nxt_control;

    // Operation sequencer
    reg [1:0] state_ff;
    reg [`NV_CNT_W-1:0] count_ff;
    reg [1:0] nxt_state;
    reg [`NV_CNT_W-1:0] nxt_count;

    // Bus slave state
    reg [7:0] awAddr_ff;
    reg awHave_ff;
    reg [31:0] wData_ff;
    reg [3:0] wStrb_ff;
    reg wHave_ff;
    reg awReady_ff;
    reg wReady_ff;
    reg bValid_ff;
    reg [1:0] bResp_ff;
    reg arReady_ff;
    reg rValid_ff;
    reg [31:0] rData_ff;
    reg [1:0] rResp_ff;
    reg stall_ff;
    reg [7:0] nxt_awAddr;
    reg nxt_awHave;
    reg [31:0] nxt_wData;
    reg [3:0] nxt_wStrb;
    reg nxt_wHave;
    reg nxt_awReady;
    reg nxt_wReady;
    reg nxt_bValid;
    reg [1:0] nxt_bResp;
    reg nxt_arReady;
    reg nxt_rValid;
    reg [31:0] nxt_rData;
    reg [1:0] nxt_rResp;
    reg nxt_busy;

    // Decoded strobes into the storage array
    reg memErase;
    reg memProgram;
    reg doWrite;
    reg opDone;
    reg [2:0] wIdx;
    reg [2:0] rIdx;
    reg [7:0] wByte;

    // Outputs straight from flip-flops
    assign awready = awReady_ff;
    assign wready = wReady_ff;
    assign bvalid = bValid_ff;
    assign bresp = bResp_ff;
    assign arready = arReady_ff;
    assign rvalid = rValid_ff;
    assign rdata = rData_ff;
    assign rresp = rResp_ff;
    assign cpuStall = stall_ff;

    // Next-state logic for registers, sequencer and bus channels
    always @* begin
        nxt_wordAddr = wordAddr_ff;
        nxt_dataLow = dataLow_ff;
        nxt_dataHigh = dataHigh_ff;
        nxt_control = control_ff;
        nxt_state = state_ff;
        nxt_count = count_ff;
        nxt_awAddr = awAddr_ff;
        nxt_awHave = awHave_ff;
        nxt_wData = wData_ff;
        nxt_wStrb = wStrb_ff;
        nxt_wHave = wHave_ff;
        nxt_bValid = bValid_ff;
        nxt_bResp = bResp_ff;
        nxt_rValid = rValid_ff;
        nxt_rData = rData_ff;
        nxt_rResp = rResp_ff;
        memErase = 1'b0;
        memProgram = 1'b0;
        wIdx = regIndex(awAddr_ff);
        rIdx = regIndex(araddr);
        wByte = wData_ff[7:0];
        // Writes apply only between operations, once both halves are held
        doWrite = awHave_ff && wHave_ff && !bValid_ff && (state_ff == ST_IDLE);
        opDone = (state_ff != ST_IDLE) && (count_ff == CNT_ONE);

        // Capture address and data independently, in either order
        if (awvalid && awReady_ff) begin
            nxt_awAddr = awaddr;
            nxt_awHave = 1'b1;
        end
        if (wvalid && wReady_ff) begin
            nxt_wData = wdata;
            nxt_wStrb = wstrb;
            nxt_wHave = 1'b1;
        end

        // Register write; byte lane 0 carries every implemented bit
        if (doWrite) begin
            nxt_awHave = 1'b0;
            nxt_wHave = 1'b0;
            nxt_bValid = 1'b1;
            nxt_bResp = (wIdx == IDX_NONE) ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
            if (wStrb_ff[0]) begin
                case (wIdx)
                    IDX_ADDR: nxt_wordAddr = wByte[`NV_ADDR_W-1:0];
                    IDX_LOW: nxt_dataLow = wByte;
                    IDX_HIGH: nxt_dataHigh = wByte[`NV_HIGH_W-1:0];
                    IDX_CTL: begin
                        nxt_control = wByte;
                        // A trigger sticks only if its enable was set beforehand
                        nxt_control[`NV_CTL_ERASE_TRIG] = wByte[`NV_CTL_ERASE_TRIG]
                            && control_ff[`NV_CTL_ERASE_EN];
                        nxt_control[`NV_CTL_WRITE_TRIG] = wByte[`NV_CTL_WRITE_TRIG]
                            && control_ff[`NV_CTL_WRITE_EN];
                        nxt_control[`NV_CTL_READ_TRIG] = wByte[`NV_CTL_READ_TRIG]
                            && control_ff[`NV_CTL_READ_EN];
                        // Erase outranks write, write outranks read
                        if (nxt_control[`NV_CTL_ERASE_TRIG]) begin
                            nxt_state = ST_ERASE;
                            nxt_count = progCycles(wByte[`NV_CTL_SEL_HI:`NV_CTL_SEL_LO]);
                            nxt_control[`NV_CTL_WRITE_TRIG] = 1'b0;
                            nxt_control[`NV_CTL_READ_TRIG] = 1'b0;
                        end else if (nxt_control[`NV_CTL_WRITE_TRIG]) begin
                            nxt_state = ST_WRITE;
                            nxt_count = progCycles(wByte[`NV_CTL_SEL_HI:`NV_CTL_SEL_LO]);
                            nxt_control[`NV_CTL_READ_TRIG] = 1'b0;
                        end else if (nxt_control[`NV_CTL_READ_TRIG]) begin
                            nxt_state = ST_READ;
                            nxt_count = READ_CYCLES[`NV_CNT_W-1:0];
                        end
                    end
                    default: nxt_control = control_ff;
                endcase
            end
        end

        // Write response retires on its handshake
        if (bValid_ff && bready) begin
            nxt_bValid = 1'b0;
        end

        // Count down the running operation
        if ((state_ff != ST_IDLE) && !opDone) begin
            nxt_count = count_ff - CNT_ONE;
        end

        // Completion: commit erase/write to the array or load the read word, and clear the finished bits
        if (opDone) begin
            nxt_state = ST_IDLE;
            nxt_count = {`NV_CNT_W{1'b0}};
            case (state_ff)
                ST_ERASE: begin
                    memErase = 1'b1;
                    nxt_control[`NV_CTL_ERASE_EN] = 1'b0;
                    nxt_control[`NV_CTL_ERASE_TRIG] = 1'b0;
                end
                ST_WRITE: begin
                    memProgram = 1'b1;
                    nxt_control[`NV_CTL_WRITE_EN] = 1'b0;
                    nxt_control[`NV_CTL_WRITE_TRIG] = 1'b0;
                end
                ST_READ: begin
                    // Read enable stays set for further reads
                    {nxt_dataHigh, nxt_dataLow} = store[wordAddr_ff];
                    nxt_control[`NV_CTL_READ_TRIG] = 1'b0;
                end
                default: nxt_state = ST_IDLE;
            endcase
        end

        // Read channel: answer one cycle after the address is taken
        if (arvalid && arReady_ff) begin
            nxt_rValid = 1'b1;
            nxt_rResp = `AXI_RESP_OKAY;
            case (rIdx)
                IDX_ADDR: nxt_rData = {27'h0000000, wordAddr_ff};
                IDX_LOW: nxt_rData = {24'h000000, dataLow_ff};
                IDX_HIGH: nxt_rData = {26'h0000000, dataHigh_ff};
                IDX_CTL: nxt_rData = {24'h000000, control_ff};
                default: begin
                    nxt_rData = 32'h00000000;
                    nxt_rResp = `AXI_RESP_SLVERR;
                end
            endcase
        end else if (rValid_ff && rready) begin
            nxt_rValid = 1'b0;
        end

        // Readies drop while busy, so the bus master sees the stall
        nxt_busy = (nxt_state != ST_IDLE);
        nxt_awReady = !nxt_awHave && !nxt_bValid && !nxt_busy;
        nxt_wReady = !nxt_wHave && !nxt_bValid && !nxt_busy;
        nxt_arReady = !nxt_rValid && !nxt_busy;
    end

    // Software registers and sequencer
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            wordAddr_ff <= `NV_RST_WORD_ADDRESS;
            dataLow_ff <= `NV_RST_DATA_LOW;
            dataHigh_ff <= `NV_RST_DATA_HIGH;
            control_ff <= `NV_RST_CONTROL;
            state_ff <= ST_IDLE;
            count_ff <= {`NV_CNT_W{1'b0}};
            stall_ff <= 1'b0;
        end else begin
            wordAddr_ff <= nxt_wordAddr;
            dataLow_ff <= nxt_dataLow;
            dataHigh_ff <= nxt_dataHigh;
            control_ff <= nxt_control;
            state_ff <= nxt_state;
            count_ff <= nxt_count;
            stall_ff <= nxt_busy;
        end
    end

    // Bus slave channel state
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            awAddr_ff <= 8'h00;
            awHave_ff <= 1'b0;
            wData_ff <= 32'h00000000;
            wStrb_ff <= 4'h0;
            wHave_ff <= 1'b0;
            awReady_ff <= 1'b0;
            wReady_ff <= 1'b0;
            bValid_ff <= 1'b0;
            bResp_ff <= `AXI_RESP_OKAY;
            arReady_ff <= 1'b0;
            rValid_ff <= 1'b0;
            rData_ff <= 32'h00000000;
            rResp_ff <= `AXI_RESP_OKAY;
        end else begin
            awAddr_ff <= nxt_awAddr;
            awHave_ff <= nxt_awHave;
            wData_ff <= nxt_wData;
            wStrb_ff <= nxt_wStrb;
            wHave_ff <= nxt_wHave;
            awReady_ff <= nxt_awReady;
            wReady_ff <= nxt_wReady;
            bValid_ff <= nxt_bValid;
            bResp_ff <= nxt_bResp;
            arReady_ff <= nxt_arReady;
            rValid_ff <= nxt_rValid;
            rData_ff <= nxt_rData;
            rResp_ff <= nxt_rResp;
        end
    end

    // Storage array update; the whole page is one erase unit
    integer i;
    always @(posedge clock) begin
        if (memErase) begin
            for (i = 0; i < `NV_WORDS; i = i + 1) begin
                store[i] <= {`NV_WORD_W{1'b0}};
            end
        end else if (memProgram) begin
            // Programs the full word; pre-erase is the caller's job
            store[wordAddr_ff] <= {dataHigh_ff, dataLow_ff};
        end
    end
endmodule // emulated_nv_word_store_ctrl

// file: bench/nv_store_props.sv
// Assertion checker for the NV word store bus answers and processor stall
`timescale 1ns/1ps
module nv_store_props #(
    parameter integer PROG_BASE_CYCLES = 400000
) (
    // Clock and reset
    input logic clock,
    input logic rst,
    // Write channels
    input logic [7:0] awaddr,
    input logic [2:0] awprot,
    input logic awvalid,
    input logic awready,
    input logic [31:0] wdata,
    input logic [3:0] wstrb,
    input logic wvalid,
    input logic wready,
    input logic [1:0] bresp,
    input logic bvalid,
    input logic bready,
    // Read channels
    input logic [7:0] araddr,
    input logic [2:0] arprot,
    input logic arvalid,
    input logic arready,
    input logic [31:0] rdata,
    input logic [1:0] rresp,
    input logic rvalid,
    input logic rready,
    // Stall
    input logic cpuStall
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Only the four aligned words at the bottom are mapped
    wire awMapped = awaddr[7:4] == 4'h0 && awaddr[1:0] == 2'h0;
    wire arMapped = araddr[7:4] == 4'h0 && araddr[1:0] == 2'h0;
    // Stall run length; a counter, as the longest run is far too long to unroll
    logic [31:0] stallCnt_ff;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) stallCnt_ff <= 32'h0;
        else if (cpuStall) stallCnt_ff <= stallCnt_ff + 32'h1;
        else stallCnt_ff <= 32'h0;
    end
    sequence wrTaken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence rdTaken;
        arvalid && arready;
    endsequence
    // Write is applied one edge after both halves are taken, answer shows the edge after
    AST_WR_OKAY: assert property (wrTaken ##0 awMapped |=> ##1 bvalid && bresp == 2'h0)
        else $error("mapped write not answered okay");
    AST_WR_SLVERR: assert property (wrTaken ##0 !awMapped |=> ##1 bvalid && bresp == 2'h2)
        else $error("unmapped write not refused");
    AST_RD_MAPPED: assert property (rdTaken ##0 arMapped |=> rvalid && rresp == 2'h0
        && rdata[31:8] == 24'h0)
        else $error("mapped read answer wrong");
    AST_RD_SLVERR: assert property (rdTaken ##0 !arMapped |=> rvalid && rresp == 2'h2
        && rdata == 32'h0)
        else $error("unmapped read answer wrong");
    AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    AST_STALL_BUS: assert property (cpuStall |-> !awready && !wready && !arready)
        else $error("bus accepted during stall");
    AST_STALL_LEN: assert property (stallCnt_ff <= PROG_BASE_CYCLES * 8 + 4)
        else $error("stall longer than longest cycle");
endmodule // nv_store_props

bind emulated_nv_word_store_ctrl nv_store_props #(.PROG_BASE_CYCLES(PROG_BASE_CYCLES)) props (
    .clock, .rst, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .cpuStall);

// file: bench/tb.sv
// Self-checking bench for the NV word store controller
`timescale 1ns/1ps
`include "nv_store_regs.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
    $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb;
    localparam int BASE = 8;
    logic clock = 0;
    logic rst = 1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, seed = 32'hEE48, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, cpuStall;
    logic [1:0] bresp, rresp, b;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    logic [33:0] e;
    logic [13:0] mem[32];
    logic [7:0] blk[6] = '{8'h10, 8'h04, 8'h01, 8'h30, 8'h0C, 8'h03};
    int fail_count = 0, n_tests = 0, cyc = 0, stalls = 0, n, d[4];
    // Protection tied: the block ignores it
    emulated_nv_word_store_ctrl #(.PROG_BASE_CYCLES(BASE)) dut (.clock, .rst, .awaddr,
        .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .cpuStall);
    always #2.5 clock = ~clock;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic ok(input logic [7:0] a);
        return a[7:4] == 4'h0 && a[1:0] == 2'h0;
    endfunction
    task automatic stop_test();
        if (fail_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Bus write; response ready comes late at random to stress the hold
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        bq.push_back(ok(a) ? 2'h0 : 2'h2);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1;
        wvalid <= 1;
        @(posedge clock);
        while (awvalid || wvalid) begin
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            @(posedge clock);
        end
        repeat (rnd() % 3) @(posedge clock);
        bready <= 1;
        do @(posedge clock); while (!bvalid);
        bready <= 0;
    endtask
    // Bus read; expectation queued before the request goes out
    task automatic rd(input logic [7:0] a, input logic [7:0] v);
        rq.push_back({ok(a) ? 2'h0 : 2'h2, 24'h0, ok(a) ? v : 8'h00});
        araddr <= a;
        arvalid <= 1;
        do @(posedge clock); while (!arready);
        arvalid <= 0;
        repeat (rnd() % 3) @(posedge clock);
        rready <= 1;
        do @(posedge clock); while (!rvalid);
        rready <= 0;
    endtask
    // Control write, then wait out any stall it starts and report its length
    task automatic run(input logic [7:0] c, output int k);
        stalls = 0;
        wr(`NV_OFF_CONTROL, c);
        repeat (2) @(posedge clock);
        while (cpuStall) @(posedge clock);
        k = stalls;
    endtask
    // Read every word back in reverse order against the model
    task automatic check_all();
        wr(`NV_OFF_CONTROL, 8'h02);
        for (int i = 31; i >= 0; i--) begin
            wr(`NV_OFF_WORD_ADDRESS, i[7:0]);
            run(8'h03, n);
            `CHK(n, `NV_READ_CYCLES)
            rd(`NV_OFF_DATA_LOW, mem[i][7:0]);
            rd(`NV_OFF_DATA_HIGH, {2'h0, mem[i][13:8]});
        end
        rd(`NV_OFF_CONTROL, 8'h02);
    endtask
    always @(posedge clock) begin
        if (cpuStall) stalls++;
    end
    // Hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            stop_test();
        end
    end
    // Oldest expectation taken whenever a response is handed over
    always @(posedge clock) begin
        if (bvalid && bready) begin
            b = bq.pop_front();
            `CHK(bresp, b)
        end
        if (rvalid && rready) begin
            e = rq.pop_front();
            `CHK({rresp, rdata}, e)
        end
    end
    initial begin
        repeat (12) @(posedge clock);
        rst <= 0;
        @(posedge clock);
        // Reset values and holes in the map
        rd(`NV_OFF_WORD_ADDRESS, 8'h00);
        rd(`NV_OFF_DATA_LOW, 8'h00);
        rd(`NV_OFF_DATA_HIGH, 8'h00);
        rd(`NV_OFF_CONTROL, 8'h00);
        rd(8'h10, 8'h00);
        wr(8'h14, 8'hFF);
        wr(`NV_OFF_WORD_ADDRESS, 8'hFF);
        rd(`NV_OFF_WORD_ADDRESS, 8'h1F);
        wr(`NV_OFF_DATA_HIGH, 8'hFF);
        rd(`NV_OFF_DATA_HIGH, 8'h3F);
        n = rnd();
        wr(`NV_OFF_DATA_LOW, n[7:0]);
        rd(`NV_OFF_DATA_LOW, n[7:0]);
        // Lane 0 strobe off: the write is answered but changes nothing
        wstrb <= 4'h0;
        wr(`NV_OFF_DATA_LOW, ~n[7:0]);
        wstrb <= 4'hF;
        rd(`NV_OFF_DATA_LOW, n[7:0]);
        // Triggers without an earlier enable start nothing
        foreach (blk[i]) begin
            run(blk[i], n);
            `CHK(n, 0)
            wr(`NV_OFF_CONTROL, 8'h00);
        end
        // Erase at every duration; lengths differ by the selected multiple
        for (int s = 0; s < 4; s++) begin
            wr(`NV_OFF_CONTROL, {s[1:0], 6'h20});
            run({s[1:0], 6'h30}, d[s]);
            rd(`NV_OFF_CONTROL, {s[1:0], 6'h00});
            `CHK(d[s] - d[0], BASE * ((1 << s) - 1))
            `CHK(d[s], BASE << s)
        end
        // Program every word of the page with random data
        for (int i = 0; i < 32; i++) begin
            n = rnd();
            mem[i] = n[13:0];
            wr(`NV_OFF_WORD_ADDRESS, i[7:0]);
            wr(`NV_OFF_DATA_LOW, mem[i][7:0]);
            wr(`NV_OFF_DATA_HIGH, {2'h0, mem[i][13:8]});
            wr(`NV_OFF_CONTROL, 8'h08);
            run(8'h0C, n);
            `CHK(n, BASE)
        end
        rd(`NV_OFF_CONTROL, 8'h00);
        check_all();
        // A fresh erase leaves the whole page zero
        wr(`NV_OFF_CONTROL, 8'h20);
        run(8'h30, n);
        `CHK(n, BASE)
        foreach (mem[i]) mem[i] = 14'h0;
        check_all();
        @(posedge clock);
        // Every noted answer must have been handed over
        `CHK(bq.size() + rq.size(), 0)
        stop_test();
    end
endmodule // tb
